/* lbx_exception_unit.sv */
/*
 * Local bus parity generation and checking, exception propagation,
 * watchdog handling and the local bus hang timer, with an APB register
 * file. Assumes local bus and host-side strobes come from logic on
 * I_CLK; only the watchdog pin is asynchronous.
 */
`timescale 1ns/10ps
module lbx_exception_unit (
    input wire logic I_CLK,
    input wire logic I_RESET_N,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [7:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    input wire logic I_LB_ADS,
    input wire logic I_LB_READY,
    input wire logic I_LB_LAST,
    input wire logic I_LB_WR,
    input wire logic [31:0] I_LB_ADDR,
    input wire logic [31:0] I_LB_DATA,
    input wire logic [3:0] I_LB_AP,
    input wire logic [3:0] I_LB_DP,
    input wire logic [1:0] I_LB_OWNER,
    input wire logic I_LB_EXCPT_N,
    output logic O_LB_EXCPT_O,
    output logic O_LB_EXCPT_OE_N,
    input wire logic [31:0] I_DRV_ADDR,
    input wire logic [31:0] I_DRV_DATA,
    output logic [3:0] O_LB_AP,
    output logic [3:0] O_LB_DP,
    output logic [3:0] O_EXP_AP,
    output logic [3:0] O_EXP_DP,
    input wire logic I_MC_MASTER,
    input wire logic I_SBI_SLAVE,
    output logic O_SLAVE_BLOCK,
    input wire logic I_HOST_XFER,
    input wire logic I_HOST_IS_PCI,
    input wire logic I_HOST_REQ,
    input wire logic [31:0] I_HOST_ADDR,
    output logic O_HOST_DATA_VALID,
    output logic [31:0] O_HOST_DATA,
    output logic O_STREAM_STOP,
    output logic O_TARGET_ABORT,
    output logic O_TARGET_DISCONNECT,
    output logic O_CHANNEL_NOT_READY_N,
    output logic O_CHANNEL_CHECK_N,
    output logic O_PAR_EXC_IRQ,
    input wire logic [1:0] I_DMA_CH,
    output logic [1:0] O_DMA_STOP,
    output logic [1:0] O_TERM_IRQ,
    input wire logic I_WATCHDOG_N,
    output logic O_HOST_IRQ
);
    // Even parity per byte: bit is the XOR of the byte
    function automatic logic [3:0] lane_par(input logic [31:0] w);
        lane_par = {^w[31:24], ^w[23:16], ^w[15:8], ^w[7:0]};
    endfunction

    logic [31:0] local_bus_config_reg;
    logic [31:0] processor_config_reg;
    logic [31:0] special_arbitration_reg;
    logic [7:0] bus_exception_status_reg;
    logic [31:0] exception_address_trap_reg;
    logic [1:0] parity_exception_reg;
    logic [3:0] bus_master_status_reg;
    logic command_busy_status_port;
    logic [31:0] rd_snap_reg;
    logic [31:0] addr_hold_reg;
    logic [6:0] to_cnt_reg;
    logic to_run_reg;
    logic to_hit_reg;
    logic wd_s1_reg;
    logic wd_s2_reg;
    logic wd_prev_reg;
    logic [31:0] fail_addr_reg;
    logic fail_pend_reg;
    logic nrdy_reg;
    logic [7:0] nrdy_cnt_reg;

    logic mc_chk, sbi_chk, exc_in, ap_err, dp_err;
    logic host_rd_fail_par, host_rd_fail_exc, host_rd_fail, host_wr_exc;
    logic to_start, slave_dp_exc, wd_event, bus_done;
    logic apb_setup, apb_wr, apb_rd;
    logic [1:0] dma_fail_par, dma_fail_exc;

    // Local bus error detection
    assign mc_chk = local_bus_config_reg[lbx_pkg::LOCAL_BUS_CONFIG_REG_CHK];
    assign sbi_chk = processor_config_reg[lbx_pkg::PROC_CHK];
    assign exc_in = ~I_LB_EXCPT_N;
    assign ap_err = I_LB_ADS & (lane_par(I_LB_ADDR) != I_LB_AP);
    assign dp_err = I_LB_READY & (lane_par(I_LB_DATA) != I_LB_DP);
    assign slave_dp_exc = I_SBI_SLAVE & sbi_chk & dp_err;

    // Host-side read and write outcomes
    assign host_rd_fail_par = I_HOST_XFER & ~I_LB_WR & sbi_chk & dp_err;
    assign host_rd_fail_exc = I_HOST_XFER & ~I_LB_WR & I_LB_READY & exc_in;
    assign host_rd_fail = host_rd_fail_par | host_rd_fail_exc;
    assign host_wr_exc = I_HOST_XFER & I_LB_WR & I_LB_READY & exc_in;

    // DMA channel failures, per channel
    assign dma_fail_par = I_DMA_CH & {2{~I_LB_WR & sbi_chk & dp_err}};
    assign dma_fail_exc = I_DMA_CH & {2{I_LB_READY & exc_in}};

    // Watchdog falling edge seen after the synchroniser
    assign wd_event = wd_prev_reg & ~wd_s2_reg;

    // APB phases
    assign apb_setup = I_PSEL & ~I_PENABLE;
    assign bus_done = I_PSEL & I_PENABLE & O_PREADY;
    assign apb_wr = bus_done & I_PWRITE;
    assign apb_rd = bus_done & ~I_PWRITE;

    // Timer start condition, disabled by the arbitration register
    assign to_start = (I_LB_ADS | I_LB_READY)
        & ~special_arbitration_reg[lbx_pkg::SPECIAL_ARBITRATION_REG_TO_DIS];

    // APB handshake: one wait-free access cycle after setup
    always_ff @(posedge I_CLK) begin
        if (!I_RESET_N) begin
            O_PREADY <= 1'b0;
        end else begin
            O_PREADY <= apb_setup;
        end
    end

    // Read data and error captured in the setup cycle
    always_ff @(posedge I_CLK) begin
        if (!I_RESET_N) begin
            O_PRDATA <= lbx_pkg::RST_ZERO;
            O_PSLVERR <= 1'b0;
            rd_snap_reg <= lbx_pkg::RST_ZERO;
        end else if (apb_setup) begin
            O_PSLVERR <= 1'b0;
            case (I_PADDR)
                lbx_pkg::OFF_LOCAL_BUS_CONFIG_REG: O_PRDATA <= local_bus_config_reg;
                lbx_pkg::OFF_PROC: O_PRDATA <= processor_config_reg;
                lbx_pkg::OFF_SPECIAL_ARBITRATION_REG: O_PRDATA <= special_arbitration_reg;
                lbx_pkg::OFF_EXSTAT: O_PRDATA <= {24'h000000, bus_exception_status_reg};
                lbx_pkg::OFF_TRAP: O_PRDATA <= exception_address_trap_reg;
                lbx_pkg::OFF_PEXC: O_PRDATA <= {30'h0, parity_exception_reg};
                lbx_pkg::OFF_BUS_MASTER_STATUS_REG: O_PRDATA <= {28'h0000000, bus_master_status_reg};
                lbx_pkg::OFF_COMMAND_BUSY_STATUS_PORT: O_PRDATA <= {31'h0, command_busy_status_port};
                default: begin
                    O_PRDATA <= lbx_pkg::RST_ZERO;
                    O_PSLVERR <= 1'b1;
                end
            endcase
            rd_snap_reg <= (I_PADDR == lbx_pkg::OFF_PEXC)
                ? {30'h0, parity_exception_reg} : lbx_pkg::RST_ZERO;
        end
    end

    // Configuration registers written by software
    always_ff @(posedge I_CLK) begin
        if (!I_RESET_N) begin
            local_bus_config_reg <= lbx_pkg::RST_ZERO;
            processor_config_reg <= lbx_pkg::RST_ZERO;
            special_arbitration_reg <= lbx_pkg::RST_ZERO;
        end else if (apb_wr) begin
            case (I_PADDR)
                lbx_pkg::OFF_LOCAL_BUS_CONFIG_REG: local_bus_config_reg <= I_PWDATA;
                lbx_pkg::OFF_PROC: processor_config_reg <= I_PWDATA;
                lbx_pkg::OFF_SPECIAL_ARBITRATION_REG: special_arbitration_reg <= I_PWDATA;
                default: ;
            endcase
        end
    end

    // Parity generation for driven address and data, also to the connector
    always_ff @(posedge I_CLK) begin
        if (!I_RESET_N) begin
            O_LB_AP <= 4'h0;
            O_LB_DP <= 4'h0;
            O_EXP_AP <= 4'h0;
            O_EXP_DP <= 4'h0;
        end else begin
            O_LB_AP <= lane_par(I_DRV_ADDR);
            O_LB_DP <= lane_par(I_DRV_DATA);
            O_EXP_AP <= lane_par(I_DRV_ADDR);
            O_EXP_DP <= lane_par(I_DRV_DATA);
        end
    end

    // Slave ignores a cycle whose address parity fails; no status kept
    always_ff @(posedge I_CLK) begin
        if (!I_RESET_N) begin
            O_SLAVE_BLOCK <= 1'b0;
        end else if (I_LB_ADS) begin
            O_SLAVE_BLOCK <= I_SBI_SLAVE & sbi_chk & ap_err;
        end else if (I_LB_READY & I_LB_LAST) begin
            O_SLAVE_BLOCK <= 1'b0;
        end
    end

    // Hang timer: counts from strobe or ready, cleared on ready
    always_ff @(posedge I_CLK) begin
        if (!I_RESET_N) begin
            to_cnt_reg <= 7'h00;
            to_run_reg <= 1'b0;
            to_hit_reg <= 1'b0;
        end else if (special_arbitration_reg[lbx_pkg::SPECIAL_ARBITRATION_REG_TO_DIS]) begin
            to_cnt_reg <= 7'h00;
            to_run_reg <= 1'b0;
            to_hit_reg <= 1'b0;
        end else if (to_start) begin
            to_cnt_reg <= 7'h00;
            to_run_reg <= ~(I_LB_READY & I_LB_LAST);
            to_hit_reg <= 1'b0;
        end else if (to_run_reg) begin
            if (to_cnt_reg == lbx_pkg::LB_TO_LAST) begin
                to_hit_reg <= 1'b1;
            end else begin
                to_cnt_reg <= to_cnt_reg + 7'h01;
            end
        end
    end

    // Open-drain exception: driven low during timeout or slave data error
    always_ff @(posedge I_CLK) begin
        if (!I_RESET_N) begin
            O_LB_EXCPT_O <= 1'b0;
            O_LB_EXCPT_OE_N <= 1'b1;
        end else begin
            O_LB_EXCPT_O <= 1'b0;
            O_LB_EXCPT_OE_N <= ~((to_hit_reg & ~to_start) | slave_dp_exc);
        end
    end

    // Address of current cycle, kept for the trap and host failure
    always_ff @(posedge I_CLK) begin
        if (!I_RESET_N) begin
            addr_hold_reg <= lbx_pkg::RST_ZERO;
        end else if (I_LB_ADS) begin
            addr_hold_reg <= I_LB_ADDR;
        end
    end

    // Memory controller exception status; write one to clear, set wins
    always_ff @(posedge I_CLK) begin
        if (!I_RESET_N) begin
            bus_exception_status_reg <= 8'h00;
            exception_address_trap_reg <= lbx_pkg::RST_ZERO;
        end else begin
            if (apb_wr && I_PADDR == lbx_pkg::OFF_EXSTAT) begin
                bus_exception_status_reg <= bus_exception_status_reg & ~I_PWDATA[7:0];
            end
            if (I_MC_MASTER & ~I_LB_WR & mc_chk & dp_err) begin
                bus_exception_status_reg[lbx_pkg::EX_MPE] <= 1'b1;
                if (!bus_exception_status_reg[lbx_pkg::EX_MPE]) begin
                    exception_address_trap_reg <= addr_hold_reg;
                end
            end
            if (I_MC_MASTER & exc_in & O_LB_EXCPT_OE_N) begin
                bus_exception_status_reg[lbx_pkg::EX_MEX] <= 1'b1;
            end
            if (to_run_reg & ~to_hit_reg & ~to_start && to_cnt_reg == lbx_pkg::LB_TO_LAST) begin
                bus_exception_status_reg[lbx_pkg::EX_EXS] <= 1'b1;
                bus_exception_status_reg[lbx_pkg::EX_OWN_LO +: 2] <= I_LB_OWNER;
                bus_exception_status_reg[lbx_pkg::EX_COND_LO +: 2] <= lbx_pkg::COND_TIMEOUT;
            end else if (I_MC_MASTER & mc_chk & dp_err & I_LB_WR) begin
                bus_exception_status_reg[lbx_pkg::EX_EXS] <= 1'b1;
                bus_exception_status_reg[lbx_pkg::EX_OWN_LO +: 2] <= I_LB_OWNER;
                bus_exception_status_reg[lbx_pkg::EX_COND_LO +: 2] <= lbx_pkg::COND_DPAR;
            end
        end
    end

    // Parity/exception status: cleared by reading it, new events win
    always_ff @(posedge I_CLK) begin
        if (!I_RESET_N) begin
            parity_exception_reg <= 2'h0;
        end else begin
            parity_exception_reg <= (parity_exception_reg
                & ~(apb_rd ? rd_snap_reg[1:0] : 2'h0))
                | {host_rd_fail_exc, host_rd_fail_par};
        end
    end

    // Parity/exception interrupt follows the status bits
    always_ff @(posedge I_CLK) begin
        if (!I_RESET_N) begin
            O_PAR_EXC_IRQ <= 1'b0;
        end else begin
            O_PAR_EXC_IRQ <= |parity_exception_reg;
        end
    end

    // Host data path: failing data is never forwarded
    always_ff @(posedge I_CLK) begin
        if (!I_RESET_N) begin
            O_HOST_DATA_VALID <= 1'b0;
            O_HOST_DATA <= lbx_pkg::RST_ZERO;
            O_STREAM_STOP <= 1'b0;
            O_TARGET_ABORT <= 1'b0;
            O_TARGET_DISCONNECT <= 1'b0;
        end else begin
            O_HOST_DATA_VALID <= I_HOST_XFER & ~I_LB_WR & I_LB_READY & ~host_rd_fail;
            if (I_HOST_XFER & ~I_LB_WR & I_LB_READY & ~host_rd_fail) begin
                O_HOST_DATA <= I_LB_DATA;
            end
            O_STREAM_STOP <= host_rd_fail & ~I_HOST_IS_PCI;
            O_TARGET_ABORT <= host_rd_fail & I_HOST_IS_PCI;
            O_TARGET_DISCONNECT <= host_wr_exc & I_HOST_IS_PCI;
        end
    end

    // Failing address remembered for a later channel re-access
    always_ff @(posedge I_CLK) begin
        if (!I_RESET_N) begin
            fail_addr_reg <= lbx_pkg::RST_ZERO;
            fail_pend_reg <= 1'b0;
        end else if (host_rd_fail & ~I_HOST_IS_PCI) begin
            fail_addr_reg <= addr_hold_reg;
            fail_pend_reg <= 1'b1;
        end else if (nrdy_reg & ~I_HOST_REQ) begin
            fail_pend_reg <= 1'b0;
        end
    end

    // Channel not-ready hold and check after the timeout
    always_ff @(posedge I_CLK) begin
        if (!I_RESET_N) begin
            nrdy_reg <= 1'b0;
            nrdy_cnt_reg <= 8'h00;
            O_CHANNEL_NOT_READY_N <= 1'b1;
            O_CHANNEL_CHECK_N <= 1'b1;
        end else begin
            O_CHANNEL_CHECK_N <= ~(host_rd_fail_exc & ~I_HOST_IS_PCI);
            if (!nrdy_reg) begin
                nrdy_cnt_reg <= 8'h00;
                if (fail_pend_reg & I_HOST_REQ & ~I_HOST_IS_PCI && I_HOST_ADDR == fail_addr_reg) begin
                    nrdy_reg <= 1'b1;
                    O_CHANNEL_NOT_READY_N <= 1'b0;
                end
            end else if (!I_HOST_REQ) begin
                nrdy_reg <= 1'b0;
                O_CHANNEL_NOT_READY_N <= 1'b1;
            end else if (processor_config_reg[lbx_pkg::PROC_NRDY_TO_DIS]) begin
                nrdy_cnt_reg <= 8'h00;
            end else if (nrdy_cnt_reg == lbx_pkg::NRDY_LAST) begin
                O_CHANNEL_CHECK_N <= 1'b0;
                nrdy_reg <= 1'b0;
                O_CHANNEL_NOT_READY_N <= 1'b1;
            end else begin
                nrdy_cnt_reg <= nrdy_cnt_reg + 8'h01;
            end
        end
    end

    // Bus master status per channel {exception, parity}; write one to clear
    always_ff @(posedge I_CLK) begin
        if (!I_RESET_N) begin
            bus_master_status_reg <= 4'h0;
        end else begin
            bus_master_status_reg <= (bus_master_status_reg
                & ~((apb_wr && I_PADDR == lbx_pkg::OFF_BUS_MASTER_STATUS_REG) ? I_PWDATA[3:0] : 4'h0))
                | {dma_fail_exc[1], dma_fail_par[1], dma_fail_exc[0], dma_fail_par[0]};
        end
    end

    // Channel stop pulses and termination interrupts
    always_ff @(posedge I_CLK) begin
        if (!I_RESET_N) begin
            O_DMA_STOP <= 2'h0;
            O_TERM_IRQ <= 2'h0;
        end else begin
            O_DMA_STOP <= dma_fail_par | dma_fail_exc | {2{wd_event}};
            O_TERM_IRQ <= {|bus_master_status_reg[3:2], |bus_master_status_reg[1:0]};
        end
    end

    // Watchdog pin synchroniser and edge detect
    always_ff @(posedge I_CLK) begin
        if (!I_RESET_N) begin
            wd_s1_reg <= 1'b1;
            wd_s2_reg <= 1'b1;
            wd_prev_reg <= 1'b1;
        end else begin
            wd_s1_reg <= I_WATCHDOG_N;
            wd_s2_reg <= wd_s1_reg;
            wd_prev_reg <= wd_s2_reg;
        end
    end

    // Watchdog status and host interrupt, never gated by the enable bit
    always_ff @(posedge I_CLK) begin
        if (!I_RESET_N) begin
            command_busy_status_port <= 1'b0;
            O_HOST_IRQ <= 1'b0;
        end else begin
            if (wd_event) begin
                command_busy_status_port <= 1'b1;
            end else if (apb_wr && I_PADDR == lbx_pkg::OFF_COMMAND_BUSY_STATUS_PORT && I_PWDATA[lbx_pkg::COMMAND_BUSY_STATUS_PORT_WDOG]) begin
                command_busy_status_port <= 1'b0;
            end
            O_HOST_IRQ <= command_busy_status_port;
        end
    end
endmodule

/* lbx_pkg.sv */
/*
 * Shared constants for the local bus parity, exception and timeout unit:
 * register offsets, field positions, reset values and timing counts.
 * Assumes a 40 MHz local bus clock and 32-bit APB register access.
 */
package lbx_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_LOCAL_BUS_CONFIG_REG = 8'h00;
    localparam logic [7:0] OFF_PROC = 8'h04;
    localparam logic [7:0] OFF_SPECIAL_ARBITRATION_REG = 8'h08;
    localparam logic [7:0] OFF_EXSTAT = 8'h0C;
    localparam logic [7:0] OFF_TRAP = 8'h10;
    localparam logic [7:0] OFF_PEXC = 8'h14;
    localparam logic [7:0] OFF_BUS_MASTER_STATUS_REG = 8'h18;
    localparam logic [7:0] OFF_COMMAND_BUSY_STATUS_PORT = 8'h1C;
    // Field positions
    localparam int LOCAL_BUS_CONFIG_REG_CHK = 0;
    localparam int PROC_EI = 1;
    localparam int PROC_CHK = 9;
    localparam int PROC_NRDY_TO_DIS = 12;
    localparam int SPECIAL_ARBITRATION_REG_TO_DIS = 0;
    localparam int EX_MPE = 0;
    localparam int EX_MEX = 1;
    localparam int EX_EXS = 2;
    localparam int EX_OWN_LO = 4;
    localparam int EX_COND_LO = 6;
    localparam int PEXC_PAR = 0;
    localparam int PEXC_EXC = 1;
    localparam int COMMAND_BUSY_STATUS_PORT_WDOG = 0;
    // Exception source condition codes
    localparam logic [1:0] COND_TIMEOUT = 2'h1;
    localparam logic [1:0] COND_DPAR = 2'h2;
    // Reset values
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;
    // Timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int LB_TIMEOUT_CLKS = 64;
    localparam int NRDY_TIMEOUT_NS = 3400;
    localparam int NRDY_CYCLES = (NRDY_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] NRDY_LAST = 8'(NRDY_CYCLES - 1);
    localparam logic [6:0] LB_TO_LAST = 7'(LB_TIMEOUT_CLKS - 1);
endpackage

/* lbx_exception_unit_asserts.sv */
/* Port checker for the local bus exception unit.
   Assumes the bind at the foot attaches it to every unit instance. */
`timescale 1ns/10ps
module lbx_exception_unit_asserts (
    input wire logic I_CLK,
    input wire logic I_RESET_N,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic O_PREADY,
    input wire logic [31:0] I_DRV_DATA,
    input wire logic [3:0] O_LB_DP,
    input wire logic [3:0] O_EXP_DP,
    input wire logic O_HOST_DATA_VALID,
    input wire logic O_TARGET_ABORT,
    input wire logic O_STREAM_STOP,
    input wire logic I_HOST_REQ,
    input wire logic O_CHANNEL_NOT_READY_N,
    input wire logic O_CHANNEL_CHECK_N,
    input wire logic [1:0] O_DMA_STOP,
    input wire logic [1:0] O_TERM_IRQ,
    input wire logic I_WATCHDOG_N,
    input wire logic O_HOST_IRQ
);
    // Even parity of each byte lane
    function automatic logic [3:0] par(input logic [31:0] v);
        return {^v[31:24], ^v[23:16], ^v[15:8], ^v[7:0]};
    endfunction
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RESET_N);
    // Parity outputs, bus answer and host side reactions
    a_data_parity: assert property (
        $past(I_RESET_N, 2) |-> O_LB_DP == par($past(I_DRV_DATA)))
        else $error("Data parity output wrong");
    a_connector_copy: assert property (O_EXP_DP == O_LB_DP)
        else $error("Connector parity differs");
    a_apb_answer: assert property (I_PSEL && !I_PENABLE |=> O_PREADY ##1 !O_PREADY)
        else $error("Register access answer wrong");
    a_abort_no_data: assert property (O_TARGET_ABORT |-> !O_HOST_DATA_VALID)
        else $error("Data passed with target abort");
    a_stop_no_data: assert property (O_STREAM_STOP |-> !O_HOST_DATA_VALID)
        else $error("Data passed with stream stop");
    a_nrdy_on_req: assert property (!O_CHANNEL_NOT_READY_N |-> $past(I_HOST_REQ))
        else $error("Not-ready without host access");
    a_check_pulse: assert property (!O_CHANNEL_CHECK_N |=> O_CHANNEL_CHECK_N)
        else $error("Channel check longer than a cycle");
    // A stop not caused by the watchdog edge raises its termination interrupt next cycle
    a_term_irq: assert property (
        O_DMA_STOP != 2'h0 && $past(I_WATCHDOG_N, 4) == $past(I_WATCHDOG_N, 3)
        |=> (O_TERM_IRQ & $past(O_DMA_STOP)) == $past(O_DMA_STOP))
        else $error("Channel stop without termination interrupt");
    a_wdog_irq: assert property (!I_WATCHDOG_N [*6] |-> O_HOST_IRQ)
        else $error("Watchdog gave no host interrupt");
    c_check: cover property (!O_CHANNEL_CHECK_N);
    c_dma_stop: cover property (O_DMA_STOP[0]);
    c_wdog: cover property (O_HOST_IRQ);
endmodule
bind lbx_exception_unit lbx_exception_unit_asserts lbx_exception_unit_asserts_inst (.*);

/* lbx_lbus_model.sv */
/* Local bus master model: one address cycle and one data beat.
   Assumes the bench calls its task right after a rising clock edge. */
`timescale 1ns/10ps
module lbx_lbus_model (
    input wire logic i_clk,
    output logic o_ads = 1'b0,
    output logic o_ready = 1'b0,
    output logic [31:0] o_addr = 32'h0,
    output logic [31:0] o_data = 32'h0,
    output logic [3:0] o_ap = 4'h0,
    output logic [3:0] o_dp = 4'h0
);
    // Even parity per byte lane, as the unit expects
    function automatic logic [3:0] par(input logic [31:0] v);
        return {^v[31:24], ^v[23:16], ^v[15:8], ^v[7:0]};
    endfunction
    // Bad bit 1 spoils address parity, bit 0 data parity; a hung target gives no beat
    task automatic xfer(input logic [31:0] a, input logic [31:0] d, input logic [1:0] bad,
                        input logic hang);
        @(posedge i_clk);
        o_ads <= 1'b1;
        o_addr <= a;
        o_ap <= par(a) ^ {3'h0, bad[1]};
        @(posedge i_clk);
        o_ads <= 1'b0;
        o_addr <= ~a;
        o_ready <= !hang;
        o_data <= d;
        o_dp <= par(d) ^ {3'h0, bad[0]};
        @(posedge i_clk);
        o_ready <= 1'b0;
        o_data <= ~d;
    endtask
endmodule

/* test_local_bus_parity_exception_timeout.sv */
/* Self-checking bench for the local bus exception unit with a bus master model.
   Assumes the register map and timings of the unit package. */
`timescale 1ns/10ps
module test_local_bus_parity_exception_timeout;
    logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, wdog_n = 1'b1;
    logic hxfer = 1'b0, pci = 1'b0, req = 1'b0, sbi = 1'b0, pready, oe_n, chk_n, pirq, hirq;
    logic mcm = 1'b0, blk;
    logic address_strobe, rdy;
    logic [1:0] dma = 2'h0, tirq;
    logic [3:0] ap, dp;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, haddr = 32'h0, prdata, laddr, ldata;
    logic [31:0] rnd = 32'h0001_7A20;
    logic [31:0] expq[$];
    int num_errors = 0, n_compared = 0, cyc = 0, cnt;
    // Released exception wire is pulled up, so it follows the unit's enable
    lbx_exception_unit lbx_exception_unit_inst (
        .I_CLK(clk), .I_RESET_N(rst_n), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
        .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(),
        .I_LB_ADS(address_strobe), .I_LB_READY(rdy), .I_LB_LAST(rdy), .I_LB_WR(1'b0), .I_LB_ADDR(laddr),
        .I_LB_DATA(ldata), .I_LB_AP(ap), .I_LB_DP(dp), .I_LB_OWNER(2'h2), .I_LB_EXCPT_N(oe_n),
        .O_LB_EXCPT_O(), .O_LB_EXCPT_OE_N(oe_n), .I_DRV_ADDR(~rnd), .I_DRV_DATA(rnd),
        .O_LB_AP(), .O_LB_DP(), .O_EXP_AP(), .O_EXP_DP(), .I_MC_MASTER(mcm), .I_SBI_SLAVE(sbi),
        .O_SLAVE_BLOCK(blk), .I_HOST_XFER(hxfer), .I_HOST_IS_PCI(pci), .I_HOST_REQ(req),
        .I_HOST_ADDR(haddr), .O_HOST_DATA_VALID(), .O_HOST_DATA(), .O_STREAM_STOP(),
        .O_TARGET_ABORT(), .O_TARGET_DISCONNECT(), .O_CHANNEL_NOT_READY_N(),
        .O_CHANNEL_CHECK_N(chk_n), .O_PAR_EXC_IRQ(pirq), .I_DMA_CH(dma), .O_DMA_STOP(),
        .O_TERM_IRQ(tirq), .I_WATCHDOG_N(wdog_n), .O_HOST_IRQ(hirq));
    lbx_lbus_model lbm_inst (.i_clk(clk), .o_ads(address_strobe), .o_ready(rdy), .o_addr(laddr),
        .o_data(ldata), .o_ap(ap), .o_dp(dp));
    // Clock, random source and cycle limit
    always #12.5 clk = ~clk;
    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    always @(posedge clk) begin
        rnd <= xs(rnd);
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            num_errors++;
            finish_test();
        end
    end
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        if (num_errors == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Register access; for a read d is the expected word
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        if (!w) expq.push_back(d);
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    // Read data is matched against the oldest note
    always @(posedge clk) begin
        if (psel && pen && pready && !pwr) cmp(prdata, expq.pop_front());
    end
    // Counts cycles until the exception (w=1) or channel check (w=0) goes low
    task automatic cnt_lo(input logic w, input int lim);
        cnt = 0;
        while (cnt < lim && (w ? oe_n : chk_n) !== 1'b0) begin
            @(negedge clk);
            cnt++;
        end
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        hxfer <= 1'b1;
        lbm_inst.xfer(rnd, rnd, 2'h3, 1'b0);
        hxfer <= 1'b0;
        for (int i = 0; i < 9; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0);
        end
        apb(1'b1, lbx_pkg::OFF_PROC, 32'h0000_0200);
        // Failing host reads: channel bus, then host bus of the other kind, then no check
        for (int p = 0; p < 3; p++) begin
            if (p == 2) apb(1'b1, lbx_pkg::OFF_PROC, 32'h0000_1200);
            @(posedge clk);
            pci <= (p == 1);
            hxfer <= 1'b1;
            haddr <= rnd;
            lbm_inst.xfer(rnd, rnd, 2'h1, 1'b0);
            hxfer <= 1'b0;
            repeat (2) @(posedge clk);
            @(negedge clk);
            cmp({31'h0, pirq}, 32'h1);
            apb(1'b0, lbx_pkg::OFF_PEXC, 32'h1);
            apb(1'b0, lbx_pkg::OFF_PEXC, 32'h0);
            cmp({31'h0, pirq}, 32'h0);
            if (p != 1) begin
                req <= 1'b1;
                cnt_lo(1'b0, 200);
                cmp(32'(p ? cnt == 200 : cnt >= lbx_pkg::NRDY_CYCLES
                    && cnt <= lbx_pkg::NRDY_CYCLES + 3), 32'h1);
                @(posedge clk);
                req <= 1'b0;
            end
        end
        // Channel read with bad data parity stops channel 0; controller as master traps it
        pci <= 1'b0;
        apb(1'b1, lbx_pkg::OFF_LOCAL_BUS_CONFIG_REG, 32'h1);
        dma <= 2'h1;
        mcm <= 1'b1;
        haddr <= rnd;
        lbm_inst.xfer(rnd, rnd, 2'h1, 1'b0);
        dma <= 2'h0;
        mcm <= 1'b0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        cmp({30'h0, tirq}, 32'h1);
        apb(1'b0, lbx_pkg::OFF_BUS_MASTER_STATUS_REG, 32'h1);
        apb(1'b0, lbx_pkg::OFF_EXSTAT, 32'h1);
        apb(1'b0, lbx_pkg::OFF_TRAP, haddr);
        // Address parity error hangs the slave; second pass has the timer disabled
        for (int t = 0; t < 2; t++) begin
            sbi <= 1'b1;
            lbm_inst.xfer(rnd, rnd, 2'h2, 1'b1);
            cnt_lo(1'b1, 100);
            cmp(32'(t ? cnt == 100 : cnt >= lbx_pkg::LB_TIMEOUT_CLKS
                && cnt <= lbx_pkg::LB_TIMEOUT_CLKS + 2), 32'h1);
            cmp({31'h0, blk}, 32'h1);
            if (t == 0) begin
                apb(1'b0, lbx_pkg::OFF_PEXC, 32'h0);
                apb(1'b0, lbx_pkg::OFF_EXSTAT, 32'h0000_0065);
                apb(1'b1, lbx_pkg::OFF_SPECIAL_ARBITRATION_REG, 32'h1);
            end
        end
        @(posedge clk);
        wdog_n <= 1'b0;
        repeat (6) @(posedge clk);
        @(negedge clk);
        cmp({31'h0, hirq}, 32'h1);
        cmp({30'h0, tirq}, 32'h1);
        apb(1'b0, lbx_pkg::OFF_COMMAND_BUSY_STATUS_PORT, 32'h1);
        finish_test();
    end
endmodule
